//--- rtl/pp_consts.svh
// addresses, offsets, widths and reset values of the parallel ports
`ifndef PP_CONSTS_SVH
`define PP_CONSTS_SVH

// port base and register addresses
`define PP_LAMP_ADDR 32'hFF200000
`define PP_SWITCH_ADDR 32'hFF200040
`define PP_BUTTON_ADDR 32'hFF200050
`define PP_BUTTON_MASK_ADDR 32'hFF200058
`define PP_BUTTON_EDGE_ADDR 32'hFF20005C
`define PP_HDRA_BASE 32'hFF200060
`define PP_HDRB_BASE 32'hFF200070
`define PP_SHIELD_BASE 32'hFF200100
`define PP_SHIELD_RST_ADDR 32'hFF200110

// direction register sits one word above the data register
`define PP_DIR_OFS 32'h00000004

// implemented widths
`define PP_LAMP_W 8
`define PP_SWITCH_W 4
`define PP_BUTTON_W 2
`define PP_BIDIR_W 32
`define PP_BIDIR_N 3

// bit position of the shield reset line in its data word
`define PP_SHIELD_RST_BIT 0

// reset values
`define PP_LAMP_RST 8'h00
`define PP_BUTTON_RST 2'h0
`define PP_BIDIR_RST 32'h00000000
`define PP_SHIELD_RST_RST 1'h0
`define PP_RDATA_RST 32'h00000000
`define PP_RVALID_RST 1'h0

`endif

//--- rtl/pp_pkg.sv
// types shared by the parallel port block
package pp_pkg;

  typedef logic [31:0] pp_word_t;

  // register selected by a bus address
  typedef enum {
    PP_SEL_NONE,
    PP_SEL_LAMP,
    PP_SEL_SWITCH,
    PP_SEL_BUTTON,
    PP_SEL_MASK,
    PP_SEL_EDGE,
    PP_SEL_SHIELD_RST,
    PP_SEL_BIDIR
  } pp_sel_t;

endpackage

//--- rtl/pp_ports.sv
// memory-mapped parallel ports: lamps, switches, buttons, headers, shield
`timescale 1ns/1ps
`include "pp_consts.svh"

// Function
// - each port own base, at most four words
// - output ports have writable data register
// - input ports read current input levels
// - bidirectional ports add equal-width direction register
// - direction 0 input, 1 driven output
// - direction register at base plus four
// - 8-bit lamp register drives eight lamps
// - lamp register drops write bits above eight
// - 4-bit read-only switch register at 0xFF200040
// - button port: three 2-bit word registers
// - button data read-only, present button state
// - button mask and edge-capture registers
// - two 32-bit bidirectional header ports
// - shield port, bit n to user line n
// - one-bit port drives shield reset, active low
module pp_ports (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_read,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_rvalid,
  output logic [`PP_LAMP_W-1:0] lamp_out,
  input wire logic [`PP_SWITCH_W-1:0] slide_switches,
  input wire logic [`PP_BUTTON_W-1:0] buttons,
  input wire logic [`PP_BIDIR_W-1:0] header_a_port_in,
  output logic [`PP_BIDIR_W-1:0] header_a_port_out,
  output logic [`PP_BIDIR_W-1:0] header_a_port_oe_n,
  input wire logic [`PP_BIDIR_W-1:0] header_b_port_in,
  output logic [`PP_BIDIR_W-1:0] header_b_port_out,
  output logic [`PP_BIDIR_W-1:0] header_b_port_oe_n,
  input wire logic [`PP_BIDIR_W-1:0] shield_user_line_in,
  output logic [`PP_BIDIR_W-1:0] shield_user_line_out,
  output logic [`PP_BIDIR_W-1:0] shield_user_line_oe_n,
  output logic shield_reset_n
);

  // bases of the bidirectional ports, index 0 header a, 1 header b, 2 shield
  localparam pp_pkg::pp_word_t BIDIR_BASE [`PP_BIDIR_N] =
    '{`PP_HDRA_BASE, `PP_HDRB_BASE, `PP_SHIELD_BASE};

  // direction register addresses, one word above each data register
  localparam pp_pkg::pp_word_t BIDIR_DIR_ADDR [`PP_BIDIR_N] = '{
    `PP_HDRA_BASE + `PP_DIR_OFS,
    `PP_HDRB_BASE + `PP_DIR_OFS,
    `PP_SHIELD_BASE + `PP_DIR_OFS};

  // lamp register
  logic [`PP_LAMP_W-1:0] lamp_q;
  logic [`PP_LAMP_W-1:0] lamp_d;

  // button mask register
  logic [`PP_BUTTON_W-1:0] mask_q;
  logic [`PP_BUTTON_W-1:0] mask_d;

  // edge capture, button history and rising levels
  logic [`PP_BUTTON_W-1:0] edge_q;
  logic [`PP_BUTTON_W-1:0] edge_d;
  logic [`PP_BUTTON_W-1:0] btn_prev_q;
  logic [`PP_BUTTON_W-1:0] btn_prev_d;
  logic [`PP_BUTTON_W-1:0] btn_rise;

  // shield reset register
  logic shield_rst_q;
  logic shield_rst_d;

  // read return registers
  pp_pkg::pp_word_t rdata_q;
  pp_pkg::pp_word_t rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // read words of the single-width registers and of the ports
  pp_pkg::pp_word_t rd_single;
  pp_pkg::pp_word_t rd_bidir;

  // bidirectional port pins and state, packed per port index
  logic [`PP_BIDIR_W-1:0] bi_in [`PP_BIDIR_N];
  logic [`PP_BIDIR_W-1:0] bi_data [`PP_BIDIR_N];
  logic [`PP_BIDIR_W-1:0] bi_dir [`PP_BIDIR_N];
  logic [`PP_BIDIR_W-1:0] bi_rd [`PP_BIDIR_N];
  logic [`PP_BIDIR_W-1:0] bi_oe_n [`PP_BIDIR_N];
  logic bi_data_hit [`PP_BIDIR_N];
  logic bi_dir_hit [`PP_BIDIR_N];

  // address decode of the single-width registers
  function automatic pp_pkg::pp_sel_t pp_decode(input pp_pkg::pp_word_t addr);
    pp_pkg::pp_sel_t sel;
    case (addr)
      `PP_LAMP_ADDR: sel = pp_pkg::PP_SEL_LAMP;
      `PP_SWITCH_ADDR: sel = pp_pkg::PP_SEL_SWITCH;
      `PP_BUTTON_ADDR: sel = pp_pkg::PP_SEL_BUTTON;
      `PP_BUTTON_MASK_ADDR: sel = pp_pkg::PP_SEL_MASK;
      `PP_BUTTON_EDGE_ADDR: sel = pp_pkg::PP_SEL_EDGE;
      `PP_SHIELD_RST_ADDR: sel = pp_pkg::PP_SEL_SHIELD_RST;
      default: sel = pp_pkg::PP_SEL_NONE;
    endcase
    return sel;
  endfunction

  pp_pkg::pp_sel_t sel;
  assign sel = pp_decode(bus_addr);

  // write strobes of the single-width registers
  logic wr_lamp;
  logic wr_mask;
  logic wr_edge;
  logic wr_shield;
  assign wr_lamp = bus_write && sel == pp_pkg::PP_SEL_LAMP;
  assign wr_mask = bus_write && sel == pp_pkg::PP_SEL_MASK;
  assign wr_edge = bus_write && sel == pp_pkg::PP_SEL_EDGE;
  assign wr_shield = bus_write && sel == pp_pkg::PP_SEL_SHIELD_RST;

  // pin bundling into per-port arrays
  assign bi_in[0] = header_a_port_in;
  assign bi_in[1] = header_b_port_in;
  assign bi_in[2] = shield_user_line_in;

  // per-port data and direction registers
  genvar gi;
  generate
    for (gi = 0; gi < `PP_BIDIR_N; gi++) begin : g_bidir
      logic [`PP_BIDIR_W-1:0] data_q;
      logic [`PP_BIDIR_W-1:0] data_d;
      logic [`PP_BIDIR_W-1:0] dir_q;
      logic [`PP_BIDIR_W-1:0] dir_d;
      logic data_we;
      logic dir_we;

      // address hits and write strobes of this port
      assign bi_data_hit[gi] = bus_addr == BIDIR_BASE[gi];
      assign bi_dir_hit[gi] = bus_addr == BIDIR_DIR_ADDR[gi];
      assign data_we = bus_write && bi_data_hit[gi];
      assign dir_we = bus_write && bi_dir_hit[gi];

      // next values from bus writes
      always_comb begin
        data_d = data_q;
        dir_d = dir_q;
        if (data_we) begin
          data_d = bus_wdata;
        end
        if (dir_we) begin
          dir_d = bus_wdata;
        end
      end

      // register update
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          data_q <= `PP_BIDIR_RST;
          dir_q <= `PP_BIDIR_RST;
        end else begin
          data_q <= data_d;
          dir_q <= dir_d;
        end
      end

      // outputs show data, inputs show pin level
      assign bi_data[gi] = data_q;
      assign bi_dir[gi] = dir_q;
      assign bi_rd[gi] = (dir_q & data_q) | (~dir_q & bi_in[gi]);
      assign bi_oe_n[gi] = ~dir_q;
    end
  endgenerate

  // pin drive: low enable means driven
  assign header_a_port_out = bi_data[0];
  assign header_a_port_oe_n = bi_oe_n[0];
  assign header_b_port_out = bi_data[1];
  assign header_b_port_oe_n = bi_oe_n[1];
  assign shield_user_line_out = bi_data[2];
  assign shield_user_line_oe_n = bi_oe_n[2];

  // lamp register next value, upper write bits dropped
  always_comb begin
    lamp_d = lamp_q;
    if (wr_lamp) begin
      lamp_d = bus_wdata[`PP_LAMP_W-1:0];
    end
  end

  // lamp register update
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lamp_q <= `PP_LAMP_RST;
    end else begin
      lamp_q <= lamp_d;
    end
  end

  // button mask next value, plain storage
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = bus_wdata[`PP_BUTTON_W-1:0];
    end
  end

  // button mask update
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_q <= `PP_BUTTON_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // rising button levels against last cycle's sample
  assign btn_rise = buttons & ~btn_prev_q;

  // edge capture next value: a written 1 clears, a new edge wins
  always_comb begin
    btn_prev_d = buttons;
    edge_d = edge_q;
    if (wr_edge) begin
      edge_d = edge_q & ~bus_wdata[`PP_BUTTON_W-1:0];
    end
    edge_d = edge_d | btn_rise;
  end

  // edge capture and button history update
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      edge_q <= `PP_BUTTON_RST;
      btn_prev_q <= `PP_BUTTON_RST;
    end else begin
      edge_q <= edge_d;
      btn_prev_q <= btn_prev_d;
    end
  end

  // shield reset next value, one bit of the written word
  always_comb begin
    shield_rst_d = shield_rst_q;
    if (wr_shield) begin
      shield_rst_d = bus_wdata[`PP_SHIELD_RST_BIT];
    end
  end

  // shield reset update, line held low until software writes 1
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shield_rst_q <= `PP_SHIELD_RST_RST;
    end else begin
      shield_rst_q <= shield_rst_d;
    end
  end

  assign lamp_out = lamp_q;
  assign shield_reset_n = shield_rst_q;

  // read value of the single-width registers, upper bits zero
  always_comb begin
    rd_single = `PP_RDATA_RST;
    case (sel)
      pp_pkg::PP_SEL_LAMP: rd_single[`PP_LAMP_W-1:0] = lamp_q;
      pp_pkg::PP_SEL_SWITCH: rd_single[`PP_SWITCH_W-1:0] = slide_switches;
      pp_pkg::PP_SEL_BUTTON: rd_single[`PP_BUTTON_W-1:0] = buttons;
      pp_pkg::PP_SEL_MASK: rd_single[`PP_BUTTON_W-1:0] = mask_q;
      pp_pkg::PP_SEL_EDGE: rd_single[`PP_BUTTON_W-1:0] = edge_q;
      pp_pkg::PP_SEL_SHIELD_RST: rd_single[`PP_SHIELD_RST_BIT] = shield_rst_q;
      default: begin
      end
    endcase
  end

  // read value of the bidirectional ports, zero when none is addressed
  always_comb begin
    rd_bidir = `PP_RDATA_RST;
    for (int i = 0; i < `PP_BIDIR_N; i++) begin
      if (bi_data_hit[i]) begin
        rd_bidir = bi_rd[i];
      end
      if (bi_dir_hit[i]) begin
        rd_bidir = bi_dir[i];
      end
    end
  end

  // read return next values, the two read words never both nonzero
  always_comb begin
    rdata_d = `PP_RDATA_RST;
    rvalid_d = bus_read;
    if (bus_read) begin
      rdata_d = rd_single | rd_bidir;
    end
  end

  // read return register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= `PP_RDATA_RST;
      rvalid_q <= `PP_RVALID_RST;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_rvalid = rvalid_q;

endmodule

//--- tb/pp_board_model.sv
// board side of one bidirectional port, header or shield
`timescale 1ns/1ps
module pp_board_model (
  input wire logic [31:0] drv,
  input wire logic [31:0] oe_n,
  input wire logic [31:0] ext,
  output logic [31:0] pin
);
  // pin follows the port where enabled, else the board level
  assign pin = (drv & ~oe_n) | (ext & oe_n);
endmodule

//--- tb/pp_ports_assertions.sv
// checker for the parallel port block
`timescale 1ns/1ps
`include "pp_consts.svh"
module pp_ports_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_read,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic [7:0] lamp_out,
  input wire logic [3:0] slide_switches,
  input wire logic [31:0] header_a_port_oe_n,
  input wire logic shield_reset_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // one bus access to one address
  sequence s_wr(ad);
    bus_write && bus_addr == ad;
  endsequence
  sequence s_rd(ad);
    bus_read && bus_addr == ad;
  endsequence
  a_read_answer: assert property (bus_read |=> bus_rvalid)
    else $error("read not answered");
  a_rdata_idle: assert property (!bus_rvalid |-> bus_rdata == 32'h0)
    else $error("rdata not zero");
  a_lamp_write: assert property (s_wr(`PP_LAMP_ADDR)
    |=> {24'h0, lamp_out} == ($past(bus_wdata) & 32'hFF)) else $error("lamp value");
  a_lamp_hold: assert property (!(bus_write && bus_addr == `PP_LAMP_ADDR)
    |=> $stable(lamp_out)) else $error("lamp changed");
  a_switch_read: assert property (s_rd(`PP_SWITCH_ADDR)
    |=> bus_rdata == {28'h0, $past(slide_switches)}) else $error("switch read");
  a_dir_enable: assert property (s_wr(`PP_HDRA_BASE + `PP_DIR_OFS)
    |=> header_a_port_oe_n == ~$past(bus_wdata)) else $error("direction");
  a_shield_reset: assert property (s_wr(`PP_SHIELD_RST_ADDR)
    |=> shield_reset_n == |($past(bus_wdata) & 32'h1)) else $error("shield reset");
  a_unmapped_zero: assert property (s_rd(`PP_HDRA_BASE + 32'h8)
    |=> bus_rdata == 32'h0) else $error("unmapped read");
endmodule
bind pp_ports pp_ports_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
  .bus_write(bus_write), .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .bus_rvalid(bus_rvalid), .lamp_out(lamp_out), .slide_switches(slide_switches),
  .header_a_port_oe_n(header_a_port_oe_n), .shield_reset_n(shield_reset_n));

//--- tb/pp_ports_tb_top.sv
// self-checking bench for the parallel ports
`timescale 1ns/1ps
`include "pp_consts.svh"
module pp_ports_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic w = 1'b0;
  logic r = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sws = 4'h0;
  logic [1:0] btn = 2'h0;
  logic [31:0] ext[3] = '{32'h0, 32'h0, 32'h0};
  logic [31:0] bases[3] = '{`PP_HDRA_BASE, `PP_HDRB_BASE, `PP_SHIELD_BASE};
  logic [31:0] po[3];
  logic [31:0] pe[3];
  logic [31:0] pi[3];
  logic [31:0] rdat;
  logic [7:0] lamp;
  logic rv;
  logic srst_n;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  pp_ports u_dut (.clk_sys(clk_sys), .rst(rst), .bus_addr(addr), .bus_write(w), .bus_read(r),
    .bus_wdata(wdat), .bus_rdata(rdat), .bus_rvalid(rv), .lamp_out(lamp),
    .slide_switches(sws), .buttons(btn), .header_a_port_in(pi[0]),
    .header_a_port_out(po[0]), .header_a_port_oe_n(pe[0]), .header_b_port_in(pi[1]),
    .header_b_port_out(po[1]), .header_b_port_oe_n(pe[1]), .shield_user_line_in(pi[2]),
    .shield_user_line_out(po[2]), .shield_user_line_oe_n(pe[2]), .shield_reset_n(srst_n));
  pp_board_model u_bd0 (.drv(po[0]), .oe_n(pe[0]), .ext(ext[0]), .pin(pi[0]));
  pp_board_model u_bd1 (.drv(po[1]), .oe_n(pe[1]), .ext(ext[1]), .pin(pi[1]));
  pp_board_model u_bd2 (.drv(po[2]), .oe_n(pe[2]), .ext(ext[2]), .pin(pi[2]));
  // clock and hang guard
  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      final_report();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one word write, strobe for one cycle
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    @(negedge clk_sys);
    addr = ad;
    wdat = d;
    w = 1'b1;
    @(negedge clk_sys);
    w = 1'b0;
  endtask
  // one word read, answer one cycle later
  task automatic rd(input logic [31:0] ad, input logic [31:0] exp);
    @(negedge clk_sys);
    addr = ad;
    r = 1'b1;
    @(negedge clk_sys);
    r = 1'b0;
    check("rvalid", {31'h0, rv}, 32'h1);
    check("rdata", rdat, exp);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // test sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    check("lamp", {24'h0, lamp}, 32'h0);
    check("srst", {31'h0, srst_n}, 32'h0);
    for (int i = 0; i < 3; i++) check("oe", pe[i], 32'hFFFFFFFF);
    wr(`PP_LAMP_ADDR, 32'hFFFFFFA5);
    check("lamp", {24'h0, lamp}, 32'hA5);
    rd(`PP_LAMP_ADDR, 32'hA5);
    sws = 4'hA;
    wr(`PP_SWITCH_ADDR, 32'h5);
    rd(`PP_SWITCH_ADDR, 32'hA);
    btn = 2'h2;
    rd(`PP_BUTTON_ADDR, 32'h2);
    rd(`PP_BUTTON_EDGE_ADDR, 32'h2);
    wr(`PP_BUTTON_EDGE_ADDR, 32'h2);
    rd(`PP_BUTTON_EDGE_ADDR, 32'h0);
    wr(`PP_BUTTON_MASK_ADDR, 32'hFFFFFFFF);
    rd(`PP_BUTTON_MASK_ADDR, 32'h3);
    $display("test simple ports done");
    for (int i = 0; i < 3; i++) begin
      ext[i] = 32'h13579BDF;
      wr(bases[i] + 32'h4, 32'h0000FFFF);
      wr(bases[i], 32'hCAFEBABE);
      check("oe", pe[i], 32'hFFFF0000);
      check("out", po[i] & 32'hFFFF, 32'hBABE);
      rd(bases[i], 32'h1357BABE);
      rd(bases[i] + 32'h4, 32'h0000FFFF);
      rd(bases[i] + 32'h8, 32'h0);
    end
    $display("test bidirectional ports done");
    wr(`PP_SHIELD_RST_ADDR, 32'hFFFFFFFF);
    check("srst", {31'h0, srst_n}, 32'h1);
    rd(`PP_SHIELD_RST_ADDR, 32'h1);
    rd(32'hFF200080, 32'h0);
    $display("test shield reset done");
    final_report();
  end
endmodule
